// ==== hw/cfs_pkg.sv ====
// Constants and types shared by the condition flags and stack pointer block.
`default_nettype none

package cfs_pkg;

    // ------------------------------------------------------------------
    // Condition code layout
    // ------------------------------------------------------------------
    localparam int unsigned CC_W         = 8;
    localparam logic [7:0]  CC_FIXED     = 8'hE0;
    localparam int unsigned CC_H_POS     = 4;
    localparam int unsigned CC_I_POS     = 3;
    localparam int unsigned CC_N_POS     = 2;
    localparam int unsigned CC_Z_POS     = 1;
    localparam int unsigned CC_C_POS     = 0;
    localparam logic [7:0]  CC_RST       = 8'hE8;
    localparam int unsigned ALU_SIGN_BIT = 7;

    // ------------------------------------------------------------------
    // Stack pointer and context
    // ------------------------------------------------------------------
    localparam int unsigned SP_W       = 16;
    localparam logic [7:0]  SP_HIGH    = 8'h01;
    localparam logic [7:0]  SP_LOW_RST = 8'hFF;
    localparam logic [15:0] SP_RST     = 16'h01FF;
    localparam logic [2:0]  INT_BYTES  = 3'h5;
    localparam logic [2:0]  LAST_STEP  = 3'h4;
    localparam int unsigned CALL_BYTES = 2;
    localparam int unsigned IRQ_NUM    = 8;
    localparam int unsigned IRQ_IW     = 3;

    typedef enum logic [2:0]
    {
        CFS_CMD_NONE,
        CFS_CMD_MASK_SET,
        CFS_CMD_MASK_CLR,
        CFS_CMD_CARRY_SET,
        CFS_CMD_CARRY_CLR,
        CFS_CMD_STACK_RST,
        CFS_CMD_INTERRUPT_RETURN_INSTR
    } cfs_cmd_t;

    typedef enum logic [1:0]
    {
        CFS_IDLE,
        CFS_SAVE,
        CFS_REST
    } cfs_state_t;

endpackage

`default_nettype wire

// ==== hw/cfs_flags_stack.sv ====
// Condition code flags, stack pointer and interrupt context engine.
`default_nettype none

module cfs_flags_stack
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [7:0]                alu_res_i,
    input  wire logic [7:0]                alu_opa_i,
    input  wire logic [7:0]                alu_opb_i,
    input  wire logic                      alu_cin_i,
    input  wire logic                      alu_carry_i,
    input  wire logic                      upd_nz_i,
    input  wire logic                      upd_h_i,
    input  wire logic                      upd_c_i,
    input  wire cfs_pkg::cfs_cmd_t         cmd_i,
    input  wire logic                      cc_ld_i,
    input  wire logic [7:0]                cc_ld_data_i,
    input  wire logic                      push_i,
    input  wire logic [7:0]                push_data_i,
    input  wire logic                      pop_i,
    input  wire logic                      sp_ld_i,
    input  wire logic [7:0]                sp_ld_data_i,
    input  wire logic                      insn_end_i,
    input  wire logic                      trap_i,
    input  wire logic [cfs_pkg::IRQ_NUM-1:0] irq_req_i,
    input  wire logic [15:0]               pc_i,
    input  wire logic [7:0]                x_i,
    input  wire logic [7:0]                a_i,
    input  wire logic [7:0]                stk_rdata_i,
    output logic [7:0]                     cc_o,
    output logic [15:0]                    sp_o,
    output logic [15:0]                    stk_addr_o,
    output logic [7:0]                     stk_wdata_o,
    output logic                           stk_we_o,
    output logic                           stk_re_o,
    output logic                           busy_o,
    output logic                           entry_o,
    output logic                           entry_trap_o,
    output logic [cfs_pkg::IRQ_IW-1:0]     entry_src_o,
    output logic [cfs_pkg::IRQ_NUM-1:0]    irq_pend_o,
    output logic                           rest_done_o,
    output logic [7:0]                     rest_a_o,
    output logic [7:0]                     rest_x_o,
    output logic [15:0]                    rest_pc_o
);
    import cfs_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Carry out of the low nibble of an add.
    function automatic logic half_carry(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return s[4];
    endfunction

    // Lowest index wins among pending requests.
    function automatic logic [IRQ_IW-1:0] pick(input logic [7:0] p);
        logic [IRQ_IW-1:0] r;
        r = '0;
        for (int i = IRQ_NUM - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                r = IRQ_IW'(i);
            end
        end
        return r;
    endfunction

    // Full stack address from the varying low byte.
    function automatic logic [15:0] stk_addr(input logic [7:0] low);
        return {SP_HIGH, low};
    endfunction

    // ------------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------------
    cfs_state_t        st;
    logic [2:0]        step;
    logic              rd_vld;
    logic [2:0]        rd_step;
    logic [15:0]       snap_pc;
    logic [7:0]        snap_x;
    logic [7:0]        snap_a;
    logic [7:0]        snap_cc;
    logic              take;
    logic              rest_cc;
    logic              plain;
    logic [7:0]        ctx_byte;
    logic [7:0]        next_low;
    logic [IRQ_IW-1:0] src;

    // Entry is only decided at an instruction boundary while idle; the
    // trap ignores the mask, maskable requests need it clear.
    // trap bypasses mask
    assign take = insn_end_i && (st == CFS_IDLE) && !busy_o
                  && (cmd_i != CFS_CMD_INTERRUPT_RETURN_INSTR)
                  && (trap_i || ((|irq_pend_o) && !cc_o[CC_I_POS]));
    assign src = pick(irq_pend_o);
    assign rest_cc = rd_vld && (rd_step == 3'h0);
    assign plain = !cc_ld_i && !rest_cc;

    // Byte saved at each step, low PC first and flags last.
    // context byte order
    always_comb
    begin
        case (step)
            3'h0:    ctx_byte = snap_pc[7:0];
            3'h1:    ctx_byte = snap_pc[15:8];
            3'h2:    ctx_byte = snap_x;
            3'h3:    ctx_byte = snap_a;
            default: ctx_byte = snap_cc;
        endcase
    end

    // ------------------------------------------------------------------
    // Interrupt request latches
    // ------------------------------------------------------------------

    // A new request beats the clear of the one being taken, so a request
    // landing in the take cycle stays pending.
    // latch pending requests
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_pend_o <= '0;
        end
        else if (take && !trap_i)
        begin
            irq_pend_o <= (irq_pend_o & ~(IRQ_NUM'(1) << src)) | irq_req_i;
        end
        else
        begin
            irq_pend_o <= irq_pend_o | irq_req_i;
        end
    end

    // Entry report and context snapshot, taken in the decision cycle so
    // the saved flags are those from before the mask is raised.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            entry_o      <= 1'b0;
            entry_trap_o <= 1'b0;
            entry_src_o  <= '0;
            snap_pc      <= '0;
            snap_x       <= '0;
            snap_a       <= '0;
            snap_cc      <= CC_RST;
        end
        else
        begin
            entry_o <= take;
            if (take)
            begin
                entry_trap_o <= trap_i;
                entry_src_o  <= trap_i ? '0 : src;
                snap_pc      <= pc_i;
                snap_x       <= x_i;
                snap_a       <= a_i;
                snap_cc      <= cc_o;
            end
        end
    end

    // ------------------------------------------------------------------
    // Condition code register
    // ------------------------------------------------------------------

    // Restore from the stack wins, then a whole-register load, then the
    // per-flag updates; flags without an update hold.
    // flags hold otherwise
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            cc_o <= CC_RST;
        end
        else if (rest_cc)
        begin
            cc_o <= stk_rdata_i | CC_FIXED;
        end
        else if (cc_ld_i)
        begin
            cc_o <= cc_ld_data_i | CC_FIXED;
            // An entry taken in the same cycle must still raise the mask.
            if (take)
            begin
                cc_o[CC_I_POS] <= 1'b1;
            end
        end
        else
        begin
            cc_o[7:5] <= CC_FIXED[7:5];
            if (upd_h_i)
            begin
                cc_o[CC_H_POS] <= half_carry(alu_opa_i, alu_opb_i,
                                             alu_cin_i);
            end
            if (take || cmd_i == CFS_CMD_MASK_SET)
            begin
                cc_o[CC_I_POS] <= 1'b1;
            end
            else if (cmd_i == CFS_CMD_MASK_CLR)
            begin
                cc_o[CC_I_POS] <= 1'b0;
            end
            if (upd_nz_i)
            begin
                cc_o[CC_N_POS] <= alu_res_i[ALU_SIGN_BIT];
                cc_o[CC_Z_POS] <= (alu_res_i == 8'h00);
            end
            if (cmd_i == CFS_CMD_CARRY_SET)
            begin
                cc_o[CC_C_POS] <= 1'b1;
            end
            else if (cmd_i == CFS_CMD_CARRY_CLR)
            begin
                cc_o[CC_C_POS] <= 1'b0;
            end
            else if (upd_c_i)
            begin
                cc_o[CC_C_POS] <= alu_carry_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Stack engine
    // ------------------------------------------------------------------

    // Eight-bit arithmetic on the low byte gives the silent wrap at both
    // ends; overwritten entries are the caller's problem.
    // silent wrap
    // A stray push strobe during a restore must not turn the pops around.
    assign next_low = (st == CFS_SAVE || (st == CFS_IDLE && push_i))
                      ? sp_o[7:0] - 8'h01
                      : sp_o[7:0] + 8'h01;

    // One process owns the pointer and the stack port so that context
    // moves and single pushes or pops can never collide.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            sp_o        <= SP_RST;
            st          <= CFS_IDLE;
            step        <= '0;
            rd_vld      <= 1'b0;
            rd_step     <= '0;
            busy_o      <= 1'b0;
            stk_addr_o  <= SP_RST;
            stk_wdata_o <= '0;
            stk_we_o    <= 1'b0;
            stk_re_o    <= 1'b0;
        end
        else
        begin
            stk_we_o <= 1'b0;
            stk_re_o <= 1'b0;
            rd_vld   <= 1'b0;
            case (st)
                CFS_IDLE:
                begin
                    if (rd_vld && rd_step == LAST_STEP)
                    begin
                        busy_o <= 1'b0;
                    end
                    if (take)
                    begin
                        st     <= CFS_SAVE;
                        step   <= '0;
                        busy_o <= 1'b1;
                    end
                    else if (busy_o)
                    begin
                        sp_o <= sp_o;
                    end
                    else if (cmd_i == CFS_CMD_INTERRUPT_RETURN_INSTR)
                    begin
                        st     <= CFS_REST;
                        step   <= '0;
                        busy_o <= 1'b1;
                    end
                    else if (cmd_i == CFS_CMD_STACK_RST)
                    begin
                        sp_o <= stk_addr(SP_LOW_RST);
                    end
                    else if (sp_ld_i)
                    begin
                        sp_o <= stk_addr(sp_ld_data_i);
                    end
                    else if (push_i)
                    begin
                        stk_we_o    <= 1'b1;
                        stk_addr_o  <= sp_o;
                        stk_wdata_o <= push_data_i;
                        sp_o        <= stk_addr(next_low);
                    end
                    else if (pop_i)
                    begin
                        stk_re_o   <= 1'b1;
                        stk_addr_o <= stk_addr(next_low);
                        sp_o       <= stk_addr(next_low);
                    end
                end
                CFS_SAVE:
                begin
                    stk_we_o    <= 1'b1;
                    stk_addr_o  <= sp_o;
                    stk_wdata_o <= ctx_byte;
                    sp_o        <= stk_addr(next_low);
                    step        <= step + 3'h1;
                    if (step == LAST_STEP)
                    begin
                        st     <= CFS_IDLE;
                        busy_o <= 1'b0;
                    end
                end
                CFS_REST:
                begin
                    stk_re_o   <= 1'b1;
                    stk_addr_o <= stk_addr(next_low);
                    sp_o       <= stk_addr(next_low);
                    rd_vld     <= 1'b1;
                    rd_step    <= step;
                    step       <= step + 3'h1;
                    if (step == LAST_STEP)
                    begin
                        st <= CFS_IDLE;
                    end
                end
                default:
                begin
                    st <= CFS_IDLE;
                end
            endcase
        end
    end

    // Popped bytes arrive one cycle after each read, flags first.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            rest_done_o <= 1'b0;
            rest_a_o    <= '0;
            rest_x_o    <= '0;
            rest_pc_o   <= '0;
        end
        else
        begin
            rest_done_o <= rd_vld && (rd_step == LAST_STEP);
            if (rd_vld)
            begin
                case (rd_step)
                    3'h1:    rest_a_o        <= stk_rdata_i;
                    3'h2:    rest_x_o        <= stk_rdata_i;
                    3'h3:    rest_pc_o[15:8] <= stk_rdata_i;
                    3'h4:    rest_pc_o[7:0]  <= stk_rdata_i;
                    default: rest_a_o        <= rest_a_o;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence save_burst;
        stk_we_o [*5] ##1 !stk_we_o;
    endsequence

    sequence rest_burst;
        stk_re_o [*5] ##1 !stk_re_o;
    endsequence

    AST_FIXED_ONES: assert property (cc_o[7:5] == 3'b111)
        else $error("Fixed flag bits not one.");
    AST_HALF: assert property (upd_h_i && plain |=>
        cc_o[4] == half_carry($past(alu_opa_i), $past(alu_opb_i),
                              $past(alu_cin_i)))
        else $error("Half carry wrong.");
    AST_MASK_ENTRY: assert property (entry_o |-> cc_o[3])
        else $error("Mask not set on entry.");
    AST_MASK_BLOCK: assert property (cc_o[3] && !trap_i |=>
        !entry_o)
        else $error("Masked request taken.");
    AST_NEG: assert property (upd_nz_i && plain |=>
        cc_o[2] == $past(alu_res_i[7]))
        else $error("Negative flag wrong.");
    AST_ZERO: assert property (upd_nz_i && plain |=>
        cc_o[1] == ($past(alu_res_i) == 8'h00))
        else $error("Zero flag wrong.");
    AST_CARRY_SET: assert property (cmd_i == CFS_CMD_CARRY_SET && plain
        |=> cc_o[0])
        else $error("Carry not forced.");
    AST_SP_HIGH: assert property (sp_o[15:8] == 8'h01)
        else $error("Stack high byte changed.");
    AST_SP_RST: assert property (cmd_i == CFS_CMD_STACK_RST && !busy_o
        && !take |=> sp_o == 16'h01FF)
        else $error("Stack reset failed.");
    AST_ENTRY_FIVE: assert property (entry_o |-> ##1 save_burst
        ##0 sp_o[7:0] == 8'($past(sp_o[7:0], 6) - 8'h05))
        else $error("Entry did not save five bytes.");
    AST_PCL_FIRST: assert property (entry_o |=>
        stk_addr_o == $past(sp_o) && stk_wdata_o == $past(pc_i[7:0], 2))
        else $error("Low PC not first.");
    AST_REST_FIVE: assert property (cmd_i == CFS_CMD_INTERRUPT_RETURN_INSTR && !busy_o
        && !take |=> ##1 rest_burst ##0 rest_done_o)
        else $error("Return did not pop five bytes.");

endmodule

`default_nettype wire

// ==== verif/cfs_stack_ram.sv ====
// Stack memory model standing on the far side of the stack port.
`default_nettype none

module cfs_stack_ram
(
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] stk_addr_i,
    input  wire logic [7:0]  stk_wdata_i,
    input  wire logic        stk_we_i,
    input  wire logic        stk_re_i,
    output logic [7:0]       stk_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The page byte is fixed, so only the low address byte picks a cell.
    logic [7:0] mem [256];
    logic [7:0] last;

    // Writes land at the edge; the last read value is kept for the idle bus.
    always_ff @(posedge sys_clk_i)
    begin
        if (stk_we_i)
            mem[stk_addr_i[7:0]] <= stk_wdata_i;
        if (stk_re_i)
            last <= mem[stk_addr_i[7:0]];
    end

    // Outside a read the bus shows the inverse of the last value, so a late
    // sample cannot pass by luck.
    assign stk_rdata_o = stk_re_i ? mem[stk_addr_i[7:0]] : ~last;
endmodule

`default_nettype wire

// ==== verif/tb_cfs_flags_stack.sv ====
// Self-checking bench for the condition flags and stack pointer block.
`default_nettype none

module tb_cfs_flags_stack;
    timeunit 1ns;
    timeprecision 1ps;
    import cfs_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i, alu_cin_i, alu_carry_i, upd_nz_i;
    logic                 upd_h_i, upd_c_i, cc_ld_i, push_i, pop_i, sp_ld_i;
    logic                 insn_end_i, trap_i, stk_we_o, stk_re_o, busy_o;
    logic                 entry_o, entry_trap_o, rest_done_o;
    logic [7:0]           alu_res_i, alu_opa_i, alu_opb_i, cc_ld_data_i;
    logic [7:0]           push_data_i, sp_ld_data_i, x_i, a_i, stk_rdata_i;
    logic [7:0]           cc_o, stk_wdata_o, rest_a_o, rest_x_o;
    logic [IRQ_NUM-1:0]   irq_req_i, irq_pend_o;
    logic [IRQ_IW-1:0]    entry_src_o;
    logic [15:0]          pc_i, sp_o, stk_addr_o, rest_pc_o;
    cfs_cmd_t             cmd_i;
    int                   failures, n_checks;
    logic [7:0]           ctx [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'hE0};

    cfs_flags_stack u_cfs_flags_stack (.*);

    cfs_stack_ram u_cfs_stack_ram
    (
        .sys_clk_i   (sys_clk_i),
        .stk_addr_i  (stk_addr_o),
        .stk_wdata_i (stk_wdata_o),
        .stk_we_i    (stk_we_o),
        .stk_re_i    (stk_re_o),
        .stk_rdata_o (stk_rdata_i)
    );

    // Free-running 250 MHz core clock.
    always #2 sys_clk_i = ~sys_clk_i;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        chk(what, {8'h00, exp}, {8'h00, got});
    endtask

    task automatic arm;
        @(posedge sys_clk_i);
    endtask

    // Lets the request edge pass, drops every strobe and waits for settling.
    task automatic fire;
        @(posedge sys_clk_i);
        {upd_nz_i, upd_h_i, upd_c_i, cc_ld_i} <= 4'h0;
        {push_i, pop_i, sp_ld_i, insn_end_i, trap_i} <= 5'h00;
        cmd_i     <= CFS_CMD_NONE;
        irq_req_i <= '0;
        #1;
    endtask

    // One-cycle flag update; the whole byte is compared so stray changes show.
    task automatic flag_op(input logic [2:0] upd, input cfs_cmd_t cm,
                           input logic [7:0] exp, input logic [7:0] res = 0,
                           input logic [7:0] opa = 0, opb = 0,
                           input logic [1:0] cc_in = 0);
        arm;
        {upd_nz_i, upd_h_i, upd_c_i} <= upd;
        {alu_cin_i, alu_carry_i} <= cc_in;
        cmd_i     <= cm;
        alu_res_i <= res;
        alu_opa_i <= opa;
        alu_opb_i <= opb;
        fire;
        chk8("flags", exp, cc_o);
    endtask

    // kind is {push, pop, load}; d is the byte written, read or loaded.
    task automatic stack_op(input logic [2:0] kind, input logic [7:0] d,
                            input logic [15:0] addr, sp);
        arm;
        {push_i, pop_i, sp_ld_i} <= kind;
        push_data_i  <= d;
        sp_ld_data_i <= d;
        fire;
        chk("stack pointer", sp, sp_o);
        chk8("strobes", {6'h0, kind[2:1]}, {6'h0, stk_we_o, stk_re_o});
        if (kind[2] | kind[1])
            chk("stack address", addr, stk_addr_o);
        if (kind[2])
            chk8("write data", d, stk_wdata_o);
        if (kind[1])
            chk8("read data", d, stk_rdata_i);
    endtask

    // Bounded wait for the context engine to go idle.
    task automatic wait_idle;
        for (int i = 0; i < 12 && busy_o !== 1'b0; i++)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        chk8("busy", 8'h00, {7'h0, busy_o});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {sys_rst_i, alu_cin_i, alu_carry_i, upd_nz_i, upd_h_i} = 5'h10;
        {upd_c_i, cc_ld_i, push_i, pop_i, sp_ld_i} = 5'h00;
        {insn_end_i, trap_i} = 2'h0;
        {alu_res_i, alu_opa_i, alu_opb_i, cc_ld_data_i} = 32'h0;
        {push_data_i, sp_ld_data_i} = 16'h0;
        irq_req_i = '0;
        cmd_i = CFS_CMD_NONE;
        pc_i = 16'h1234;
        x_i = 8'h56;
        a_i = 8'h78;
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        fire;
        chk8("flags", 8'hE8, cc_o);
        chk("stack pointer", 16'h01FF, sp_o);
        flag_op(3'b100, CFS_CMD_NONE, 8'hEC, 8'h80);
        flag_op(3'b100, CFS_CMD_NONE, 8'hEA, 8'h00);
        flag_op(3'b010, CFS_CMD_NONE, 8'hFA, 0, 8'h08, 8'h07, 2'b10);
        flag_op(3'b010, CFS_CMD_NONE, 8'hEA, 8'hFF, 8'h10, 8'h01);
        flag_op(3'b000, CFS_CMD_CARRY_SET, 8'hEB);
        flag_op(3'b001, CFS_CMD_CARRY_CLR, 8'hEA, 0, 0, 0, 2'b01);
        flag_op(3'b001, CFS_CMD_NONE, 8'hEB, 0, 0, 0, 2'b01);
        flag_op(3'b000, CFS_CMD_MASK_CLR, 8'hE3);
        flag_op(3'b000, CFS_CMD_MASK_SET, 8'hEB);
        arm;
        cc_ld_i <= 1'b1;
        fire;
        chk8("flags", 8'hE0, cc_o);
        flag_op(3'b000, CFS_CMD_MASK_SET, 8'hE8);
        stack_op(3'b100, 8'hAA, 16'h01FF, 16'h01FE);
        stack_op(3'b010, 8'hAA, 16'h01FF, 16'h01FF);
        stack_op(3'b001, 8'h00, 16'h0000, 16'h0100);
        stack_op(3'b100, 8'h55, 16'h0100, 16'h01FF);
        stack_op(3'b010, 8'h55, 16'h0100, 16'h0100);
        flag_op(3'b000, CFS_CMD_STACK_RST, 8'hE8);
        chk("stack pointer", 16'h01FF, sp_o);
        // A masked request must wait in the pending latch.
        arm;
        irq_req_i <= 8'h04;
        fire;
        chk8("pending", 8'h04, irq_pend_o);
        arm;
        insn_end_i <= 1'b1;
        fire;
        chk8("entry", 8'h00, {7'h0, entry_o});
        flag_op(3'b000, CFS_CMD_MASK_CLR, 8'hE0);
        arm;
        insn_end_i <= 1'b1;
        fire;
        chk8("entry", 8'h0A, {3'h0, entry_trap_o, entry_o, entry_src_o});
        chk8("flags", 8'hE8, cc_o);
        chk8("pending", 8'h00, irq_pend_o);
        wait_idle;
        // The last context byte lands in the model one edge after busy falls.
        fire;
        chk("stack pointer", 16'h01FA, sp_o);
        for (int i = 0; i < 5; i++)
            chk8("context", ctx[i], u_cfs_stack_ram.mem[8'(255 - i)]);
        arm;
        cmd_i <= CFS_CMD_INTERRUPT_RETURN_INSTR;
        fire;
        wait_idle;
        chk8("restore done", 8'h01, {7'h0, rest_done_o});
        chk("restored pc", 16'h1234, rest_pc_o);
        chk8("restored x", 8'h56, rest_x_o);
        chk8("restored a", 8'h78, rest_a_o);
        chk8("flags", 8'hE0, cc_o);
        chk("stack pointer", 16'h01FF, sp_o);
        // The software trap must enter even with the mask set.
        flag_op(3'b000, CFS_CMD_MASK_SET, 8'hE8);
        arm;
        trap_i     <= 1'b1;
        insn_end_i <= 1'b1;
        fire;
        chk8("entry", 8'h18, {3'h0, entry_trap_o, entry_o, entry_src_o});
        wait_idle;
        fire;
        chk("stack pointer", 16'h01FA, sp_o);
        chk8("saved flags", 8'hE8, u_cfs_stack_ram.mem[8'hFB]);
        report_and_stop;
    end

    // Watchdog: the sequence needs a few hundred cycles at most.
    initial
    begin
        repeat (2000) @(posedge sys_clk_i);
        failures++;
        report_and_stop;
    end
endmodule

`default_nettype wire
